// ==== lcc_pkg.sv ====
package lcc_pkg;

  // configuration word offsets (byte addresses)
  localparam logic [7:0] LCC_OFF_LINK_CAP  = 8'h7c;
  localparam logic [7:0] LCC_OFF_LINK_CTRL = 8'h80;

  // fixed fields of the link capabilities word
  localparam logic [7:0] LCC_PORT_NUM       = 8'h00;
  localparam logic [1:0] LCC_CAP_RSVD       = 2'h0;
  localparam logic [0:0] LCC_BW_NOTIFY      = 1'h0;
  localparam logic [0:0] LCC_ACTIVE_REPORT  = 1'h0;
  localparam logic [0:0] LCC_SURPRISE_DOWN  = 1'h0;
  localparam logic [0:0] LCC_REFCLK_PM_CAP  = 1'h1;
  localparam logic [2:0] LCC_L0S_COMMON     = 3'h3;
  localparam logic [2:0] LCC_L0S_SEPARATE   = 3'h4;
  localparam logic [1:0] LCC_ASPM_SUPPORT   = 2'h3;
  localparam logic [5:0] LCC_MAX_WIDTH      = 6'h01;
  localparam logic [3:0] LCC_MAX_RATE       = 4'h1;

  // diagnostic word fields feeding the deep idle exit time
  localparam int LCC_DIAG_A_LSB = 18;
  localparam int LCC_DIAG_B_LSB = 15;

  // general control word fields giving link control reset values
  localparam int LCC_GEN_REFCLK_BIT = 23;
  localparam int LCC_GEN_ASPM_LSB   = 28;

  // link control bit positions
  localparam int LCC_CTL_REFCLK = 8;
  localparam int LCC_CTL_XSYNC  = 7;
  localparam int LCC_CTL_CCC    = 6;
  localparam int LCC_CTL_RCB    = 3;
  localparam int LCC_CTL_ASPM   = 0;

  // byte lanes of a configuration word
  localparam int LCC_BE_LO = 0;
  localparam int LCC_BE_HI = 1;

  // one configuration access, held for a single cycle
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } lcc_cfg_req_t;

  // writable state of the link control register
  typedef struct packed {
    logic       refclock_power_enable;
    logic       extended_sync;
    logic       common_clock;
    logic       read_boundary;
    logic [1:0] active_power_control;
  } lcc_ctrl_t;

  localparam lcc_ctrl_t LCC_CTRL_RESET = '{default: 1'b0};

endpackage

// ==== lcc_exit_time.sv ====
`timescale 1ns/1ps
module lcc_exit_time
  import lcc_pkg::*;
(
  input  wire logic        common_clock_in,
  input  wire logic [31:0] diag_reg_in,
  output logic      [2:0]  deep_idle_exit_time_out,
  output logic      [2:0]  standby_exit_time_out
);

  logic [2:0] diag_exit_time_a;
  logic [2:0] diag_exit_time_b;

  // slices of the diagnostic word
  assign diag_exit_time_a = diag_reg_in[LCC_DIAG_A_LSB +: 3];
  assign diag_exit_time_b = diag_reg_in[LCC_DIAG_B_LSB +: 3];

  // kept combinational so a read right after a change sees it
  always_comb begin
    if (common_clock_in) begin
      deep_idle_exit_time_out = diag_exit_time_a; // R8 R18
      standby_exit_time_out   = LCC_L0S_COMMON;   // R10
    end else begin
      deep_idle_exit_time_out = diag_exit_time_b; // R9 R18
      standby_exit_time_out   = LCC_L0S_SEPARATE; // R11
    end
  end

endmodule

// ==== lcc_regs.sv ====
`timescale 1ns/1ps
// Function
// R1 - capabilities word at 7Ch, 32-bit read-only, writes change nothing
// R2 - port number bits 31:24 always read 00h
// R3 - capabilities bits 23:22 reserved, read 00b
// R4 - bandwidth notification capability bit 21 fixed 0
// R5 - active reporting bit 20 and surprise down bit 19 read 0
// R6 - bit 18 fixed 1: reference clock power management supported
// R7 - link control bit 6: 1 shared clock, 0 separate clocks
// R8 - shared clock: deep idle exit time shows diagnostic bits 20:18
// R9 - separate clocks: deep idle exit time shows diagnostic bits 17:15
// R10 - shared clock: standby exit time reads 011b
// R11 - separate clocks: standby exit time reads 100b
// R12 - active power support bits 11:10 read 11b
// R13 - max lane width bits 9:4 read 000001b
// R14 - max signal rate bits 3:0 read 1h
// R15 - link control at 80h, 16 bits, zero reset except 8 and 1:0
// R16 - link control bit 8 resets from general control bit 23
// R17 - link control bits 1:0 reset from general control bits 29:28
// R18 - exit times follow clock bit and diagnostic word without delay
module lcc_regs
  import lcc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic         clk_sys_in,
  input  wire logic         resetn_in,
  input  wire lcc_cfg_req_t cfg_req_in,
  input  wire logic [31:0]  diag_reg_in,
  input  wire logic [31:0]  gen_ctrl_reg_in,
  input  wire logic [15:0]  link_status_in,
  output logic      [31:0]  cfg_rdata_out,
  output logic              cfg_rvalid_out,
  output logic              cfg_hit_out,
  output logic              refclock_power_enable_out,
  output logic              extended_sync_out,
  output logic              common_clock_out,
  output logic              read_boundary_out,
  output logic      [1:0]   active_power_control_out
);

  // the decoder takes eight address bits and compares bits 7:2
  if (ADDR_W != 8) begin : g_bad_addr
    $error("lcc_regs: ADDR_W must be 8");
  end

  typedef enum logic [1:0] {
    LCC_ST_LOAD = 2'b01,
    LCC_ST_RUN  = 2'b10
  } lcc_state_t;

  lcc_state_t  state_reg;
  lcc_ctrl_t   ctrl_reg;
  lcc_ctrl_t   ctrl_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        rvalid_reg;
  logic        hit_cap;
  logic        hit_ctrl;
  logic [2:0]  deep_idle_exit_time;
  logic [2:0]  standby_exit_time;
  logic [31:0] cap_word;

  // word-aligned decode; the low two address bits pick no lane
  function automatic logic word_hit(input logic [7:0] a,
                                    input logic [7:0] off);
    word_hit = (a[7:2] == off[7:2]);
  endfunction

  // packs the writable state into the 16-bit control layout
  function automatic logic [15:0] ctrl_view(input lcc_ctrl_t c);
    logic [15:0] v;
    v = 16'h0000;
    v[LCC_CTL_REFCLK]      = c.refclock_power_enable;
    v[LCC_CTL_XSYNC]       = c.extended_sync;
    v[LCC_CTL_CCC]         = c.common_clock;
    v[LCC_CTL_RCB]         = c.read_boundary;
    v[LCC_CTL_ASPM +: 2]   = c.active_power_control;
    ctrl_view = v;
  endfunction

  assign hit_cap  = word_hit(cfg_req_in.addr, LCC_OFF_LINK_CAP);
  assign hit_ctrl = word_hit(cfg_req_in.addr, LCC_OFF_LINK_CTRL);

  // exit times recomputed from the live clock selection
  lcc_exit_time u_exit_time (
    .common_clock_in         (ctrl_reg.common_clock),
    .diag_reg_in             (diag_reg_in),
    .deep_idle_exit_time_out (deep_idle_exit_time),
    .standby_exit_time_out   (standby_exit_time)
  );

  // capabilities word is pure wiring of constants and live fields
  assign cap_word = {
    LCC_PORT_NUM,        // R2
    LCC_CAP_RSVD,        // R3
    LCC_BW_NOTIFY,       // R4
    LCC_ACTIVE_REPORT,   // R5
    LCC_SURPRISE_DOWN,   // R5
    LCC_REFCLK_PM_CAP,   // R6
    deep_idle_exit_time, // R8 R9
    standby_exit_time,   // R10 R11
    LCC_ASPM_SUPPORT,    // R12
    LCC_MAX_WIDTH,       // R13
    LCC_MAX_RATE         // R14
  };

  // the defaults come from another register, so they are loaded on
  // the first edge after reset release rather than in the reset itself
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= LCC_ST_LOAD;
    end else begin
      state_reg <= LCC_ST_RUN;
    end
  end

  // next value of the writable control bits
  always_comb begin
    ctrl_next = ctrl_reg;
    unique case (state_reg)
      LCC_ST_LOAD: begin
        ctrl_next = LCC_CTRL_RESET; // R15
        ctrl_next.refclock_power_enable =
          gen_ctrl_reg_in[LCC_GEN_REFCLK_BIT]; // R16
        ctrl_next.active_power_control =
          gen_ctrl_reg_in[LCC_GEN_ASPM_LSB +: 2]; // R17
      end
      LCC_ST_RUN: begin
        // writes to the capabilities word fall through untouched
        if (cfg_req_in.wr && hit_ctrl) begin // R1
          if (cfg_req_in.be[LCC_BE_LO]) begin
            ctrl_next.extended_sync =
              cfg_req_in.wdata[LCC_CTL_XSYNC];
            ctrl_next.common_clock =
              cfg_req_in.wdata[LCC_CTL_CCC]; // R7
            ctrl_next.read_boundary =
              cfg_req_in.wdata[LCC_CTL_RCB];
            ctrl_next.active_power_control =
              cfg_req_in.wdata[LCC_CTL_ASPM +: 2];
          end
          if (cfg_req_in.be[LCC_BE_HI]) begin
            ctrl_next.refclock_power_enable =
              cfg_req_in.wdata[LCC_CTL_REFCLK];
          end
        end
      end
      default: ctrl_next = ctrl_reg;
    endcase
  end

  // control bits hold zero while reset is asserted
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_reg <= LCC_CTRL_RESET; // R15
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // read mux; the upper half of the control word is status, owned
  // elsewhere and passed straight through
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit_cap) begin
      rdata_next = cap_word; // R1
    end else if (hit_ctrl) begin
      rdata_next = {link_status_in, ctrl_view(ctrl_reg)}; // R15
    end
  end

  // read data registered; an unmapped word reads zero
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_reg  <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= cfg_req_in.rd;
      if (cfg_req_in.rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign cfg_rdata_out             = rdata_reg;
  assign cfg_rvalid_out            = rvalid_reg;
  assign cfg_hit_out               = hit_cap | hit_ctrl;
  assign refclock_power_enable_out = ctrl_reg.refclock_power_enable;
  assign extended_sync_out         = ctrl_reg.extended_sync;
  assign common_clock_out          = ctrl_reg.common_clock;
  assign read_boundary_out         = ctrl_reg.read_boundary;
  assign active_power_control_out  = ctrl_reg.active_power_control;

  // helper flags for checking: what kind of word the last read was,
  // and the clock selection and diagnostic word it saw
  logic        chk_cap_reg;
  logic        chk_ctrl_reg;
  logic        chk_ccc_reg;
  logic [31:0] chk_diag_reg;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      chk_cap_reg  <= 1'b0;
      chk_ctrl_reg <= 1'b0;
      chk_ccc_reg  <= 1'b0;
      chk_diag_reg <= 32'h0000_0000;
    end else begin
      chk_cap_reg  <= cfg_req_in.rd && hit_cap;
      chk_ctrl_reg <= cfg_req_in.rd && hit_ctrl;
      chk_ccc_reg  <= ctrl_reg.common_clock;
      chk_diag_reg <= diag_reg_in;
    end
  end

  default clocking lcc_cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  // a capabilities read answered in the next cycle
  sequence s_cap_read;
    cfg_req_in.rd && hit_cap;
  endsequence

  // a write that reaches only the capabilities word
  sequence s_cap_write;
    state_reg == LCC_ST_RUN && cfg_req_in.wr && hit_cap;
  endsequence

  // reset release followed by the default load
  sequence s_release_load;
    state_reg == LCC_ST_LOAD ##1 state_reg == LCC_ST_RUN;
  endsequence

  a_cap_write_ignored: assert property ( // R1
    s_cap_write |=> ctrl_reg == $past(ctrl_reg))
    else $error("write to capabilities word changed control bits");

  a_port_number_zero: assert property ( // R2
    s_cap_read |=> cfg_rvalid_out && cfg_rdata_out[31:24] == 8'h00)
    else $error("port number not zero");

  a_cap_reserved_zero: assert property ( // R3
    chk_cap_reg |-> cfg_rdata_out[23:22] == 2'h0)
    else $error("capabilities reserved bits not zero");

  a_unsupported_caps_zero: assert property ( // R4 R5
    chk_cap_reg |-> cfg_rdata_out[21:19] == 3'h0)
    else $error("unsupported capability bit set");

  a_refclk_pm_set: assert property ( // R6
    chk_cap_reg |-> cfg_rdata_out[18] == 1'b1)
    else $error("clock power capability not advertised");

  a_deep_idle_common: assert property ( // R8
    chk_cap_reg && chk_ccc_reg
      |-> cfg_rdata_out[17:15] == chk_diag_reg[20:18])
    else $error("shared clock exit time mismatch");

  a_deep_idle_separate: assert property ( // R9
    chk_cap_reg && !chk_ccc_reg
      |-> cfg_rdata_out[17:15] == chk_diag_reg[17:15])
    else $error("separate clock exit time mismatch");

  a_standby_exit_time: assert property ( // R10 R11
    chk_cap_reg |-> cfg_rdata_out[14:12]
      == (chk_ccc_reg ? 3'h3 : 3'h4))
    else $error("standby exit time wrong");

  a_fixed_link_fields: assert property ( // R12 R13 R14
    chk_cap_reg |-> cfg_rdata_out[11:0] == 12'hc11)
    else $error("support, width or rate field wrong");

  a_ccc_write_seen: assert property ( // R7
    state_reg == LCC_ST_RUN && cfg_req_in.wr && hit_ctrl
      && cfg_req_in.be[0]
      |=> common_clock_out == $past(cfg_req_in.wdata[6]))
    else $error("common clock bit not written");

  a_ctrl_reserved_zero: assert property ( // R15
    chk_ctrl_reg |-> cfg_rdata_out[15:9] == 7'h00
      && cfg_rdata_out[5:4] == 2'h0 && cfg_rdata_out[2] == 1'b0)
    else $error("link control read-only bits not zero");

  a_default_load: assert property ( // R16 R17
    s_release_load |-> refclock_power_enable_out
      == $past(gen_ctrl_reg_in[23])
      && active_power_control_out == $past(gen_ctrl_reg_in[29:28]))
    else $error("link control defaults not loaded");

  a_fresh_exit_time: assert property ( // R18
    $changed(ctrl_reg.common_clock) && cfg_req_in.rd && hit_cap
      |=> cfg_rdata_out[14:12] == ($past(ctrl_reg.common_clock)
      ? 3'h3 : 3'h4))
    else $error("exit time stale after clock change");

  // read handshake: valid follows exactly the cycles that carried a read
  a_read_answered: assert property ( // R1
    cfg_req_in.rd |=> cfg_rvalid_out)
    else $error("read not answered in the next cycle");

  a_no_spurious_valid: assert property ( // R1
    !cfg_req_in.rd |=> !cfg_rvalid_out)
    else $error("read valid without a read request");

  a_unmapped_read_zero: assert property ( // R1
    cfg_req_in.rd && !hit_cap && !hit_ctrl |=> cfg_rdata_out == 32'h0000_0000)
    else $error("unmapped word did not read zero");

  // single capability fields, checked on the answer of a read
  a_surprise_down_zero: assert property ( // R5
    chk_cap_reg |-> cfg_rdata_out[20:19] == 2'h0)
    else $error("active reporting or surprise down bit set");

  a_standby_separate: assert property ( // R11
    chk_cap_reg && !chk_ccc_reg |-> cfg_rdata_out[14:12] == 3'h4)
    else $error("separate clock standby exit time wrong");

  a_max_width_one: assert property ( // R13
    chk_cap_reg |-> cfg_rdata_out[9:4] == 6'h01)
    else $error("max lane width not one lane");

  a_max_rate_one: assert property ( // R14
    chk_cap_reg |-> cfg_rdata_out[3:0] == 4'h1)
    else $error("max signal rate field wrong");

  // status half of the control word is the status seen at the read edge
  a_status_passthrough: assert property ( // R15
    chk_ctrl_reg |-> cfg_rdata_out[31:16] == $past(link_status_in))
    else $error("link status half not passed through");

  // control bits move only on a control write after the default load, and only in their own lane
  a_ctrl_held: assert property ( // R15
    state_reg == LCC_ST_RUN && !(cfg_req_in.wr && hit_ctrl)
      |=> ctrl_reg == $past(ctrl_reg))
    else $error("control bits changed without a write");

  // a control write that carries the upper byte lane
  sequence s_ctrl_write_hi;
    state_reg == LCC_ST_RUN && cfg_req_in.wr && hit_ctrl && cfg_req_in.be[1];
  endsequence

  a_refclk_lane_write: assert property ( // R15
    s_ctrl_write_hi |=> refclock_power_enable_out == $past(cfg_req_in.wdata[8]))
    else $error("clock power enable not written from lane one");

  a_low_lane_held: assert property ( // R15
    state_reg == LCC_ST_RUN && cfg_req_in.wr && hit_ctrl && !cfg_req_in.be[0]
      |=> common_clock_out == $past(common_clock_out))
    else $error("common clock bit changed without lane zero");

endmodule

// ==== lcc_regs_tb.sv ====
`timescale 1ns/1ps
module testbench;
  import lcc_pkg::*;

  logic         clk_sys_in;
  logic         resetn_in;
  lcc_cfg_req_t cfg_req;
  logic [31:0]  diag_reg;
  logic [31:0]  gen_ctrl_reg;
  logic [15:0]  link_status;
  logic [31:0]  cfg_rdata;
  logic         cfg_rvalid;
  logic         cfg_hit;
  logic         refclk_pm_en;
  logic         ext_sync;
  logic         common_clk;
  logic         read_bound;
  logic [1:0]   aspm_ctrl;
  int           n_mismatch;
  int           num_checks;
  logic [31:0]  diag_tab [3] = '{32'h0015_0000, 32'h000b_0000, 32'hffff_ffff};

  lcc_regs #(.ADDR_W(8)) dut (
    .clk_sys_in                (clk_sys_in),
    .resetn_in                 (resetn_in),
    .cfg_req_in                (cfg_req),
    .diag_reg_in               (diag_reg),
    .gen_ctrl_reg_in           (gen_ctrl_reg),
    .link_status_in            (link_status),
    .cfg_rdata_out             (cfg_rdata),
    .cfg_rvalid_out            (cfg_rvalid),
    .cfg_hit_out               (cfg_hit),
    .refclock_power_enable_out (refclk_pm_en),
    .extended_sync_out         (ext_sync),
    .common_clock_out          (common_clk),
    .read_boundary_out         (read_bound),
    .active_power_control_out  (aspm_ctrl)
  );

  // 25 MHz system clock
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  // capability word built from the field layout, not from the design
  function automatic logic [31:0] cap_word(input logic c, input logic [31:0] d);
    return {8'h00, 2'h0, 1'h0, 1'h0, 1'h0, 1'h1, (c ? d[20:18] : d[17:15]),
            (c ? 3'h3 : 3'h4), 2'h3, 6'h01, 4'h1};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // link control halfword rebuilt from the control outputs
  task automatic check_ctrl(input logic [15:0] exp);
    check("ctrl outputs", {16'h0, 7'h0, refclk_pm_en, ext_sync, common_clk, 2'h0, read_bound, 1'h0, aspm_ctrl},
          {16'h0, exp});
  endtask

  // request held for one edge; next task call or idle releases it
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk_sys_in);
    cfg_req <= '{1'b1, 1'b0, a, be, d};
  endtask

  task automatic idle();
    @(posedge clk_sys_in);
    cfg_req <= '0;
    #1;
  endtask

  // read answer stands one cycle after the request edge
  task automatic cfg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_in);
    cfg_req <= '{1'b0, 1'b1, a, 4'hf, 32'h0};
    #1;
    check("cfg_hit", {31'h0, cfg_hit}, {31'h0, (a[7:2] == 6'h1f) || (a[7:2] == 6'h20)});
    idle();
    check("cfg_rvalid", {31'h0, cfg_rvalid}, 32'h1);
    check("cfg_rdata", cfg_rdata, exp);
  endtask

  // reset with a write at the first edge after release, which must be dropped
  task automatic do_reset(input logic [31:0] g);
    @(posedge clk_sys_in);
    resetn_in    <= 1'b0;
    gen_ctrl_reg <= g;
    repeat (16) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    cfg_req   <= '{1'b1, 1'b0, 8'h80, 4'hf, 32'h0000_ffff};
    idle();
    check_ctrl({7'h0, g[23], 6'h0, g[29:28]});
    cfg_read(8'h80, {link_status, 7'h0, g[23], 6'h0, g[29:28]});
    $display("test reset done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    #400000;
    n_mismatch++;
    results();
  end

  initial begin
    resetn_in    = 1'b0;
    cfg_req      = '0;
    diag_reg     = 32'h0;
    gen_ctrl_reg = 32'h0;
    link_status  = 16'h1011;
    n_mismatch   = 0;
    num_checks   = 0;
    do_reset(32'h2080_0000);

    // capability word under both clock settings and several diagnostic words
    for (int c = 0; c < 2; c++) begin
      cfg_write(8'h80, 4'h1, {25'h0, c[0], 6'h0});
      idle();
      check("common_clock", {31'h0, common_clk}, {31'h0, c[0]});
      foreach (diag_tab[i]) begin
        @(posedge clk_sys_in);
        diag_reg <= diag_tab[i];
        cfg_read(8'h7c, cap_word(c[0], diag_tab[i]));
      end
    end
    $display("test capabilities done");

    // writes to the read-only capability word change nothing
    cfg_write(8'h7c, 4'hf, 32'hffff_ffff);
    cfg_write(8'h7d, 4'hf, 32'h0000_0000);
    cfg_read(8'h7e, cap_word(1'b1, diag_tab[2]));
    check_ctrl(16'h0140);
    $display("test read only done");

    // byte lanes and read-only control bits
    cfg_write(8'h80, 4'h3, 32'hffff_ffff);
    idle();
    check_ctrl(16'h01cb);
    cfg_write(8'h80, 4'hc, 32'h0000_0000);
    cfg_read(8'h82, {link_status, 16'h01cb});
    cfg_write(8'h80, 4'h1, 32'h0000_0000);
    idle();
    check_ctrl(16'h0100);
    cfg_write(8'h80, 4'h2, 32'h0000_0000);
    idle();
    check_ctrl(16'h0000);
    $display("test control done");

    // clock setting flipped and read back on the very next cycle
    @(posedge clk_sys_in);
    diag_reg <= 32'h0019_0000;
    cfg_write(8'h80, 4'h1, 32'h0000_0040);
    cfg_read(8'h7c, cap_word(1'b1, 32'h0019_0000));
    cfg_write(8'h80, 4'h1, 32'h0000_0000);
    cfg_read(8'h7c, cap_word(1'b0, 32'h0019_0000));
    $display("test back to back done");

    // unmapped words read zero and ignore writes
    cfg_write(8'h84, 4'hf, 32'hffff_ffff);
    cfg_read(8'h84, 32'h0);
    cfg_read(8'h78, 32'h0);
    cfg_read(8'h80, {link_status, 16'h0000});
    $display("test unmapped done");

    // second reset in mid-run with other defaults
    @(posedge clk_sys_in);
    link_status <= 16'h2005;
    do_reset(32'h1000_0000);
    cfg_read(8'h7c, cap_word(1'b0, 32'h0019_0000));
    results();
  end
endmodule
